//--- rtl/dpa_arbiter.sv
// Arbiter sharing the on-board dual port RAM between local CPU and an external master.
// Assumes all inputs synchronous to clk_i and the RAM controller on the same clock.
//
// Contract
// RQ1: External master may use RAM as slave memory.
// RQ2: Local CPU access wins; external waits.
// RQ3: Local requests stall while slave mode runs.
// RQ4: Command rise sets capture, clears second stage.
// RQ5: Slave stage sets, holds while second low.
// RQ6: External gate passes strobes and acknowledge.
// RQ7: Acknowledge clears capture on next edge.
// RQ8: Command removal negates gate, ends strobe.
// RQ9: Second sets, slave drops, gate rises.
// RQ10: Latch strobe presets the priority stage.
// RQ11: Local request clears capture, suppresses slave.
// RQ12: Local gate follows request while gate idle.
// RQ13: Local read or write freezes slave stage.
// RQ14: Local strobes gated; acknowledge clears capture.
// RQ15: After local cycle, pending external enters slave.
// RQ16: All stages on rising clock edge.
// RQ17: Reset leaves arbiter idle.
`timescale 1ns/1ps

`include "dpa_map.svh"

module dpa_arbiter
   import dpa_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        external_ram_command_i,
   input  wire logic        local_ram_request_n_i,
   input  wire logic        latch_strobe_n_i,
   input  wire logic        memory_read_n_i,
   input  wire logic        early_memory_write_n_i,
   input  wire logic        memory_transfer_ack_n_i,
   input  wire dpa_strobe_t strobe_req_i,
   output dpa_strobe_t      shared_strobe_o,
   output logic             slave_mode_n_o,
   output logic             ext_cmd_gate_n_o,
   output logic             local_cmd_gate_n_o,
   output logic             local_addr_gate_n_o,
   output logic             extended_latch_strobe_o,
   output logic             ext_ack_n_o,
   output logic             local_ack_n_o,
   output dpa_owner_t       owner_o
);

   // ==========================================================================
   // Stage registers and combinational request terms
   logic capture_q;
   logic second_q;
   logic slave_q;
   logic xgate_n_q;
   logic prio_q;
   logic local_hold;
   logic local_claim;
   dpa_owner_t owner_q;

   // CPU read or early write with request pins the slave stage
   assign local_hold  = ~local_ram_request_n_i & ~(memory_read_n_i & early_memory_write_n_i); // RQ13
   // Request inside the address phase of a local cycle
   assign local_claim = ~local_ram_request_n_i & prio_q;

   // ==========================================================================
   // Priority stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin // RQ16
      if (!arst_n_i) begin
         prio_q <= `DPA_PRIO_RST; // RQ17
      end else if (!latch_strobe_n_i) begin
         prio_q <= 1'h1; // RQ10
      end else if (local_ram_request_n_i) begin
         prio_q <= 1'h0;
      end
   end

   // ==========================================================================
   // Request capture stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture_q <= `DPA_CAPTURE_RST; // RQ17
      end else if (!memory_transfer_ack_n_i) begin
         capture_q <= 1'h0; // RQ7 RQ14
      end else if (local_claim) begin
         capture_q <= 1'h0; // RQ11 RQ2
      end else if (external_ram_command_i) begin
         capture_q <= 1'h1; // RQ4 RQ13 RQ15
      end else begin
         capture_q <= 1'h0;
      end
   end

   // ==========================================================================
   // Second stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         second_q <= `DPA_SECOND_RST; // RQ17
      end else if (external_ram_command_i && local_ram_request_n_i
                   && memory_transfer_ack_n_i) begin
         second_q <= 1'h0; // RQ4
      end else if (memory_transfer_ack_n_i && !external_ram_command_i) begin
         second_q <= 1'h1; // RQ9
      end
   end

   // ==========================================================================
   // Slave stage: a local access in progress keeps it from setting
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slave_q <= `DPA_SLAVE_RST; // RQ17
      end else if (slave_q) begin
         slave_q <= ~second_q; // RQ5 RQ9
      end else if (capture_q && !second_q && !local_hold && !prio_q) begin
         slave_q <= 1'h1; // RQ5 RQ1 RQ15 RQ13 RQ2
      end
   end

   // ==========================================================================
   // External command gate stage, one edge behind the slave stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         xgate_n_q <= `DPA_XGATE_N_RST; // RQ17
      end else begin
         xgate_n_q <= ~slave_q; // RQ6 RQ9
      end
   end

   // ==========================================================================
   // Owner view for debug
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         owner_q <= DPA_IDLE;
      end else begin
         case ({slave_q, ~local_cmd_gate_n_o})
            2'h0: owner_q <= DPA_IDLE;
            2'h1: owner_q <= DPA_LOCAL;
            2'h2: owner_q <= DPA_EXTERNAL;
            default: owner_q <= DPA_EXTERNAL;
         endcase
      end
   end

   // ==========================================================================
   // Gates and routing; combinational so strobes end with their cause
   assign slave_mode_n_o          = ~slave_q; // RQ5
   assign ext_cmd_gate_n_o        = xgate_n_q | ~external_ram_command_i; // RQ8
   assign local_cmd_gate_n_o      = local_ram_request_n_i | ~xgate_n_q | slave_q; // RQ12 RQ3
   assign local_addr_gate_n_o     = slave_q; // RQ11
   assign extended_latch_strobe_o = ~latch_strobe_n_i & local_ram_request_n_i;
   assign shared_strobe_o.rd_n    = strobe_req_i.rd_n
                                    | (local_cmd_gate_n_o & ext_cmd_gate_n_o); // RQ14 RQ6
   assign shared_strobe_o.wr_n    = strobe_req_i.wr_n
                                    | (local_cmd_gate_n_o & ext_cmd_gate_n_o); // RQ14 RQ6
   assign ext_ack_n_o             = memory_transfer_ack_n_i | ext_cmd_gate_n_o; // RQ6
   assign local_ack_n_o           = memory_transfer_ack_n_i | local_cmd_gate_n_o;
   assign owner_o                 = owner_q;

   // ==========================================================================
   // Checks
   sequence cmd_rise_s;
      external_ram_command_i && local_ram_request_n_i && memory_transfer_ack_n_i;
   endsequence

   sequence slave_entry_s;
      slave_q ##1 !xgate_n_q;
   endsequence

   capture_on_cmd_a: assert property ( // RQ4
      @(posedge clk_i) disable iff (!arst_n_i)
      cmd_rise_s |=> capture_q && !second_q)
      else $error("capture did not follow command");

   slave_hold_a: assert property ( // RQ5
      @(posedge clk_i) disable iff (!arst_n_i)
      slave_q && !second_q |=> slave_q)
      else $error("slave stage dropped while second low");

   gate_after_slave_a: assert property ( // RQ6
      @(posedge clk_i) disable iff (!arst_n_i)
      $rose(slave_q) |-> ##1 !xgate_n_q)
      else $error("gate did not follow slave entry");

   ack_clears_a: assert property ( // RQ7
      @(posedge clk_i) disable iff (!arst_n_i)
      !memory_transfer_ack_n_i |=> !capture_q)
      else $error("acknowledge did not clear capture");

   cmd_drop_a: assert property ( // RQ8
      @(posedge clk_i) disable iff (!arst_n_i)
      !external_ram_command_i && local_cmd_gate_n_o
      |-> ext_cmd_gate_n_o && (&shared_strobe_o))
      else $error("gate open without command");

   slave_exit_a: assert property ( // RQ9
      @(posedge clk_i) disable iff (!arst_n_i)
      slave_q && second_q |=> !slave_q ##1 xgate_n_q)
      else $error("slave exit order wrong");

   prio_preset_a: assert property ( // RQ10
      @(posedge clk_i) disable iff (!arst_n_i)
      !latch_strobe_n_i |=> prio_q)
      else $error("priority not preset");

   local_block_a: assert property ( // RQ11
      @(posedge clk_i) disable iff (!arst_n_i)
      !slave_q && local_claim |=> !capture_q ##1 !slave_q)
      else $error("local request did not suppress slave");

   local_gate_a: assert property ( // RQ12
      @(posedge clk_i) disable iff (!arst_n_i)
      !local_ram_request_n_i && xgate_n_q && !slave_q |-> !local_cmd_gate_n_o)
      else $error("local gate missing");

   local_stall_a: assert property ( // RQ3
      @(posedge clk_i) disable iff (!arst_n_i)
      slave_entry_s |-> local_cmd_gate_n_o)
      else $error("local gate during slave mode");

   freeze_slave_a: assert property ( // RQ13
      @(posedge clk_i) disable iff (!arst_n_i)
      !slave_q && local_hold |=> !slave_q)
      else $error("slave set during local access");

   strobe_gate_a: assert property ( // RQ14
      @(posedge clk_i) disable iff (!arst_n_i)
      local_cmd_gate_n_o && ext_cmd_gate_n_o |-> &shared_strobe_o)
      else $error("strobe passed without gate");

endmodule : dpa_arbiter

//--- rtl/dpa_map.svh
// Reset values and bit positions of the shared RAM access arbiter.
// Assumes inclusion by the arbiter package and design module only.
`ifndef DPA_MAP_SVH
`define DPA_MAP_SVH

// ==========================================================================
// Reset values of the sequential stages
`define DPA_CAPTURE_RST  1'h0
`define DPA_SECOND_RST   1'h1
`define DPA_SLAVE_RST    1'h0
`define DPA_XGATE_N_RST  1'h1
`define DPA_PRIO_RST     1'h0

// ==========================================================================
// Strobe field positions
`define DPA_STB_RD_BIT   0
`define DPA_STB_WR_BIT   1
`define DPA_STB_WIDTH    2

`endif

//--- rtl/dpa_pkg.sv
// Types shared by the shared RAM access arbiter.
// Assumes the map header sits in the include path.
`include "dpa_map.svh"

package dpa_pkg;

   // ==========================================================================
   // Active-low read and write strobe pair
   typedef struct packed {
      logic wr_n;
      logic rd_n;
   } dpa_strobe_t;

   // ==========================================================================
   // Coarse owner of the RAM, visible for debug
   typedef enum logic [1:0] {
      DPA_IDLE,
      DPA_LOCAL,
      DPA_EXTERNAL
   } dpa_owner_t;

endpackage : dpa_pkg

//--- testbench/dpa_ram_model.sv
// RAM controller model answering the gated shared strobes.
// Assumes it shares clk_i and arst_n_i with the arbiter.
`timescale 1ns/1ps

module dpa_ram_model
   import dpa_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [1:0]  lat_i,
   input  wire dpa_strobe_t strobe_i,
   output logic             ack_n_o
);
   // =======================================================================
   // Access time
   // Latency is set by the bench so both prompt and slow answers occur
   logic [1:0] cnt_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q   <= 2'h0;
         ack_n_o <= 1'h1;
      end else if (&strobe_i) begin
         cnt_q   <= 2'h0;
         ack_n_o <= 1'h1;
      end else if (cnt_q == lat_i) begin
         ack_n_o <= 1'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule : dpa_ram_model

//--- testbench/tb_dual_port_ram_access_arbiter.sv
// Bench for the shared RAM access arbiter.
// Assumes the RAM controller model acknowledges the gated strobes.
`timescale 1ns/1ps

module tb_dual_port_ram_access_arbiter import dpa_pkg::*; ;
   // =======================================================================
   // Signals
   logic        clk_i, arst_n_i, cmd, req_n, latch_n, mrd_n, mwr_n, ack_n;
   logic        slave_n, xgate_n, lgate_n, addr_n, ext_latch, xack_n, lack_n;
   dpa_owner_t  own;
   logic [1:0]  lat;
   dpa_strobe_t stb_req, stb;
   int          num_errors, total_checks, i;

   dpa_arbiter u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .external_ram_command_i(cmd),
      .local_ram_request_n_i(req_n), .latch_strobe_n_i(latch_n), .memory_read_n_i(mrd_n),
      .early_memory_write_n_i(mwr_n), .memory_transfer_ack_n_i(ack_n),
      .strobe_req_i(stb_req), .shared_strobe_o(stb), .slave_mode_n_o(slave_n),
      .ext_cmd_gate_n_o(xgate_n), .local_cmd_gate_n_o(lgate_n),
      .local_addr_gate_n_o(addr_n), .extended_latch_strobe_o(ext_latch),
      .ext_ack_n_o(xack_n), .local_ack_n_o(lack_n), .owner_o(own));
   dpa_ram_model u_ram (.clk_i(clk_i), .arst_n_i(arst_n_i), .lat_i(lat),
      .strobe_i(stb), .ack_n_o(ack_n));

   // =======================================================================
   // Helpers
   task chk(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(negedge clk_i);
   endtask : step
   task test_done;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // A wait that ran out ends the run
   task tmo(input logic ok);
      if (!ok) begin
         num_errors++;
         test_done();
      end
   endtask : tmo

   // =======================================================================
   // Scenarios
   task ext_start(input dpa_strobe_t s);
      cmd = 1'h1;
      stb_req = s;
      lat = 2'h3;
      step(1); chk(slave_n, 1'h1);
      step(1); chk(slave_n, 1'h0);
      chk(addr_n, 1'h1);
      step(1); chk(xgate_n, 1'h0);
      chk(stb.rd_n, s.rd_n);
      chk(stb.wr_n, s.wr_n);
      chk(own == DPA_EXTERNAL, 1'h1);
   endtask : ext_start
   task ext_end;
      for (i = 0; i < 20 && xack_n !== 1'h0; i++) step(1);
      tmo(xack_n === 1'h0);
      chk(lack_n, 1'h1);
      step(1);
      cmd = 1'h0;
      stb_req = 2'h3;
      #1 chk(xgate_n, 1'h1);
      chk(stb.rd_n & stb.wr_n, 1'h1);
      step(2); chk(slave_n, 1'h0);
      step(1); chk(slave_n, 1'h1);
      $display("external access done");
   endtask : ext_end
   // Local read or early write while an external command is pending
   task local_acc(input logic rd);
      latch_n = 1'h0;
      cmd = 1'h1;
      lat = 2'h0;
      #1 chk(ext_latch, 1'h1);
      step(1);
      latch_n = 1'h1;
      req_n = 1'h0;
      mrd_n = ~rd;
      mwr_n = rd;
      stb_req = rd ? 2'h2 : 2'h1;
      #1 chk(lgate_n, 1'h0);
      chk(ext_latch, 1'h0);
      chk(stb.rd_n, ~rd);
      chk(stb.wr_n, rd);
      for (i = 0; i < 20 && lack_n !== 1'h0; i++) begin
         chk(slave_n, 1'h1);
         chk(addr_n, 1'h0);
         step(1);
      end
      tmo(lack_n === 1'h0);
      chk(own == DPA_LOCAL, 1'h1);
      chk(xack_n, 1'h1);
      step(1);
      {req_n, mrd_n, mwr_n} = 3'h7;
      stb_req = 2'h3;
      for (i = 0; i < 8 && slave_n !== 1'h0; i++) step(1);
      tmo(slave_n === 1'h0);
      stb_req = 2'h2;
      lat = 2'h3;
      for (i = 0; i < 8 && xgate_n !== 1'h0; i++) step(1);
      tmo(xgate_n === 1'h0);
      ext_end();
      $display("local access done");
   endtask : local_acc
   task stall;
      ext_start(2'h1);
      req_n = 1'h0;
      repeat (4) begin
         step(1);
         chk(lgate_n, 1'h1);
         chk(lack_n, 1'h1);
      end
      ext_end();
      for (i = 0; i < 8 && lgate_n !== 1'h0; i++) step(1);
      tmo(lgate_n === 1'h0);
      req_n = 1'h1;
      step(1);
      $display("stall done");
   endtask : stall

   // =======================================================================
   // Run
   initial begin
      clk_i = 1'h0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      {arst_n_i, cmd} = 2'h0;
      {req_n, latch_n, mrd_n, mwr_n} = 4'hF;
      stb_req = 2'h3;
      lat = 2'h0;
      num_errors = 0;
      total_checks = 0;
      step(2);
      chk(slave_n, 1'h1);
      chk(xgate_n, 1'h1);
      chk(stb.rd_n & stb.wr_n, 1'h1);
      chk(own == DPA_IDLE, 1'h1);
      arst_n_i = 1'h1;
      step(1);
      ext_start(2'h2);
      ext_end();
      local_acc(1'h1);
      local_acc(1'h0);
      stall();
      test_done();
   end
endmodule : tb_dual_port_ram_access_arbiter
